/* hw/srlc_pkg.sv */
// Constants, types and region decode for the serial lock command block.
// Behaviour
// - Region lock is opcode 01h plus one protection byte, chip select low.
// - Chip select rising after the full lock sequence starts the write.
// - Extra protection bytes overwrite earlier ones; last is committed.
// - After power-up the device is in standby with serial output released.
// - After power-up only a chip select fall makes the device active.
// - Write latch is cleared at power-up.
// - Writes start only if chip select rises on a byte boundary.
// - Opcode 06h sets the write latch.
// - Opcode 04h clears the write latch.
// - Code 0 protects nothing; codes 1..4 protect one quarter each.
// - Code 5 lower half, code 6 bottom page, code 7 top page.
// - Opcode 05h shifts out the lock code, or all ones while a write is in progress.
// - Opcode 02h starts a memory write: address then data bytes.
// - Opcode 03h starts a memory read: address then returned data.
// - All bytes shift most significant bit first both ways.
// - Protected addresses stay readable but refuse writes.
// - Status read drives output high while a write is in progress.
// - Write latch clears when a write cycle completes.
// - Write guard input low blocks nonvolatile writes only.
`default_nettype none
package srlc_pkg;
  localparam logic [7:0] OP_SET_WL  = 8'h06;
  localparam logic [7:0] OP_CLR_WL  = 8'h04;
  localparam logic [7:0] OP_LOCK    = 8'h01;
  localparam logic [7:0] OP_RD_STAT = 8'h05;
  localparam logic [7:0] OP_WRITE   = 8'h02;
  localparam logic [7:0] OP_READ    = 8'h03;
  localparam logic [2:0] LK_NONE    = 3'h0;
  localparam logic [2:0] LK_Q_ONE   = 3'h1;
  localparam logic [2:0] LK_Q_TWO   = 3'h2;
  localparam logic [2:0] LK_Q_THREE = 3'h3;
  localparam logic [2:0] LK_Q_FOUR  = 3'h4;
  localparam logic [2:0] LK_HALF    = 3'h5;
  localparam logic [2:0] LK_BOT_PG  = 3'h6;
  localparam logic [2:0] LK_TOP_PG  = 3'h7;
  localparam logic [2:0] LK_RESET   = 3'h0;
  localparam logic [4:0] STAT_RSVD  = 5'h00;
  localparam int ADDR_W    = 9;
  localparam int PAGE_W    = 4;
  localparam int PAGE_N    = 16;
  localparam int WC_W      = 20;
  localparam int CLK_KHZ   = 10000;
  localparam int T_WC_US   = 10000;
  localparam int POWERUP_READ_WAIT_US  = 1000;
  localparam int POWERUP_WRITE_WAIT_US  = 5000;
  localparam int WC_CYC_DEF = T_WC_US * CLK_KHZ / 1000;
  localparam int PUR_CYC = POWERUP_READ_WAIT_US * CLK_KHZ / 1000;
  localparam int PUW_CYC = POWERUP_WRITE_WAIT_US * CLK_KHZ / 1000;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic wp_n;
  } srlc_pins_t;

  typedef enum logic [2:0] {
    PH_OPC  = 3'b000,
    PH_SETW = 3'b001,
    PH_CLRW = 3'b010,
    PH_LOCK = 3'b011,
    PH_WR   = 3'b100,
    PH_RD   = 3'b101,
    PH_STAT = 3'b110,
    PH_IGN  = 3'b111
  } srlc_phase_t;

  // Returns high when the address lies in the region the code locks.
  function automatic logic srlc_locked(input logic [2:0] code,
                                       input logic [8:0] addr);
    logic hit;
    hit = 1'b0;
    case (code)
      LK_Q_ONE:   hit = (addr[8:7] == 2'h0);
      LK_Q_TWO:   hit = (addr[8:7] == 2'h1);
      LK_Q_THREE: hit = (addr[8:7] == 2'h2);
      LK_Q_FOUR:  hit = (addr[8:7] == 2'h3);
      LK_HALF:    hit = (addr[8] == 1'b0);
      LK_BOT_PG:  hit = (addr[8:4] == 5'h00);
      LK_TOP_PG:  hit = (addr[8:4] == 5'h1f);
      default:    hit = 1'b0;
    endcase
    return hit;
  endfunction
endpackage
`default_nettype wire

/* hw/srlc_top.sv */
// Command decoder, write latch and region lock of the serial memory slave.
`timescale 1ns/100ps
`default_nettype none
module srlc_top #(
  parameter int unsigned WC_CYCLES = srlc_pkg::WC_CYC_DEF
) (
  input  wire logic i_ref_clk,
  input  wire logic i_rst_n,
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_si,
  input  wire logic i_wp_n,
  output var  logic o_so,
  output var  logic o_so_oe,
  output var  logic o_standby
);
  import srlc_pkg::*;

  if (WC_CYCLES < 1 || WC_CYCLES >= (1 << WC_W)) begin : g_chk
    $error("WC_CYCLES out of range");
  end

  // Pin synchroniser; the first stage feeds only the second.
  srlc_pins_t s1_r;
  srlc_pins_t s2_r;
  srlc_pins_t p_r;

  // Reset to zero so a chip select already low never looks like a fall.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      p_r  <= '0;
    end else begin
      s1_r <= '{cs_n: i_cs_n, sck: i_sck, si: i_si, wp_n: i_wp_n};
      s2_r <= s1_r;
      p_r  <= s2_r;
    end
  end

  logic cs_fall;
  logic cs_rise;
  logic sck_rise;
  logic sck_fall;
  assign cs_fall  = p_r.cs_n & ~s2_r.cs_n;
  assign cs_rise  = ~p_r.cs_n & s2_r.cs_n;
  assign sck_rise = ~p_r.sck & s2_r.sck;
  assign sck_fall = p_r.sck & ~s2_r.sck;

  logic [7:0] mem [2**ADDR_W];
  logic [7:0] pbuf [PAGE_N];

  srlc_phase_t        ph_r,    ph_nxt;
  logic               fr_r,    fr_nxt;
  logic [2:0]         bit_r,   bit_nxt;
  logic [2:0]         bcnt_r,  bcnt_nxt;
  logic [7:0]         sh_r,    sh_nxt;
  logic [ADDR_W-1:0]  addr_r,  addr_nxt;
  logic [2:0]         lbuf_r,  lbuf_nxt;
  logic [2:0]         lock_r,  lock_nxt;
  logic               wel_r,   wel_nxt;
  logic               busy_r,  busy_nxt;
  logic [WC_W-1:0]    wc_r,    wc_nxt;
  logic [7:0]         osh_r,   osh_nxt;
  logic               so_r,    so_nxt;
  logic               oe_r,    oe_nxt;
  logic               stby_r,  stby_nxt;
  logic [PAGE_N-1:0]  pmask_r, pmask_nxt;
  logic               pb_we;
  logic               commit;
  logic [7:0]         byte_in;
  logic [7:0]         stat;
  logic               wr_ok;
  logic [ADDR_W-1:0]  rd_a;

  assign byte_in = {sh_r[6:0], s2_r.si};
  assign stat    = {STAT_RSVD, lock_r};
  assign wr_ok   = wel_r & s2_r.wp_n & ~busy_r;

  always_comb begin
    ph_nxt    = ph_r;
    fr_nxt    = fr_r;
    bit_nxt   = bit_r;
    bcnt_nxt  = bcnt_r;
    sh_nxt    = sh_r;
    addr_nxt  = addr_r;
    lbuf_nxt  = lbuf_r;
    lock_nxt  = lock_r;
    wel_nxt   = wel_r;
    busy_nxt  = busy_r;
    wc_nxt    = wc_r;
    osh_nxt   = osh_r;
    so_nxt    = so_r;
    oe_nxt    = oe_r;
    pmask_nxt = pmask_r;
    pb_we     = 1'b0;
    commit    = 1'b0;
    rd_a      = addr_r;
    if (busy_r) begin
      if (wc_r == '0) begin
        busy_nxt = 1'b0;
        wel_nxt  = 1'b0;
      end else begin
        wc_nxt = wc_r - 1'b1;
      end
    end
    if (cs_fall) begin
      fr_nxt    = 1'b1;
      ph_nxt    = PH_OPC;
      bit_nxt   = 3'h0;
      bcnt_nxt  = 3'h0;
      pmask_nxt = '0;
    end else if (cs_rise && fr_r) begin
      fr_nxt = 1'b0;
      oe_nxt = 1'b0;
      ph_nxt = PH_OPC;
      // A rise off a byte boundary drops the sequence.
      if (bit_r == 3'h0 && !busy_r) begin
        case (ph_r)
          PH_SETW: begin
            if (bcnt_r == 3'h1) begin
              wel_nxt = 1'b1;
            end
          end
          PH_CLRW: begin
            if (bcnt_r == 3'h1) begin
              wel_nxt = 1'b0;
            end
          end
          PH_LOCK: begin
            if (bcnt_r >= 3'h2 && s2_r.wp_n) begin
              lock_nxt = lbuf_r;
              busy_nxt = 1'b1;
              wc_nxt   = WC_W'(WC_CYCLES - 1);
            end
          end
          PH_WR: begin
            if (bcnt_r >= 3'h4 && s2_r.wp_n) begin
              commit   = 1'b1;
              busy_nxt = 1'b1;
              wc_nxt   = WC_W'(WC_CYCLES - 1);
            end
          end
          default: begin
          end
        endcase
      end
    end else if (sck_rise && fr_r) begin
      sh_nxt  = byte_in;
      bit_nxt = bit_r + 3'h1;
      if (bit_r == 3'h7) begin
        bcnt_nxt = (bcnt_r == 3'h7) ? bcnt_r : bcnt_r + 3'h1;
        case (ph_r)
          PH_OPC: begin
            case (byte_in)
              OP_SET_WL:  ph_nxt = PH_SETW;
              OP_CLR_WL:  ph_nxt = PH_CLRW;
              // Lock and write are refused unless the latch is set.
              OP_LOCK:    ph_nxt = wr_ok ? PH_LOCK : PH_IGN;
              OP_WRITE:   ph_nxt = wr_ok ? PH_WR : PH_IGN;
              OP_READ:    ph_nxt = PH_RD;
              OP_RD_STAT: ph_nxt = PH_STAT;
              default:    ph_nxt = PH_IGN;
            endcase
            // During a write cycle only the status read is served.
            if (busy_r && byte_in != OP_RD_STAT) begin
              ph_nxt = PH_IGN;
            end
            osh_nxt = stat;
          end
          PH_LOCK: begin
            lbuf_nxt = byte_in[2:0];
          end
          PH_WR: begin
            if (bcnt_r == 3'h1) begin
              addr_nxt[8] = byte_in[0];
            end else if (bcnt_r == 3'h2) begin
              addr_nxt[7:0] = byte_in;
            end else begin
              // The page offset wraps inside the page.
              pb_we = 1'b1;
              pmask_nxt[addr_r[3:0]] = 1'b1;
              addr_nxt[3:0] = addr_r[3:0] + 4'h1;
            end
          end
          PH_RD: begin
            if (bcnt_r == 3'h1) begin
              addr_nxt[8] = byte_in[0];
            end else begin
              if (bcnt_r == 3'h2) begin
                rd_a = {addr_r[8], byte_in};
              end
              osh_nxt  = mem[rd_a];
              addr_nxt = rd_a + 9'h001;
            end
          end
          PH_STAT: begin
            osh_nxt = stat;
          end
          default: begin
          end
        endcase
      end
    end else if (sck_fall && fr_r) begin
      if (ph_r == PH_STAT || (ph_r == PH_RD && bcnt_r >= 3'h3)) begin
        // A busy device answers a status read with ones.
        so_nxt  = (ph_r == PH_STAT && busy_r) ? 1'b1 : osh_r[7];
        osh_nxt = {osh_r[6:0], 1'b0};
        oe_nxt  = 1'b1;
      end
    end
    stby_nxt = ~fr_nxt & ~busy_nxt;
  end


  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ph_r    <= PH_OPC;
      fr_r    <= 1'b0;
      bit_r   <= 3'h0;
      bcnt_r  <= 3'h0;
      sh_r    <= 8'h00;
      addr_r  <= '0;
      lbuf_r  <= LK_NONE;
      lock_r  <= LK_RESET;
      wel_r   <= 1'b0;
      busy_r  <= 1'b0;
      wc_r    <= '0;
      osh_r   <= 8'h00;
      so_r    <= 1'b0;
      oe_r    <= 1'b0;
      stby_r  <= 1'b1;
      pmask_r <= '0;
    end else begin
      ph_r    <= ph_nxt;
      fr_r    <= fr_nxt;
      bit_r   <= bit_nxt;
      bcnt_r  <= bcnt_nxt;
      sh_r    <= sh_nxt;
      addr_r  <= addr_nxt;
      lbuf_r  <= lbuf_nxt;
      lock_r  <= lock_nxt;
      wel_r   <= wel_nxt;
      busy_r  <= busy_nxt;
      wc_r    <= wc_nxt;
      osh_r   <= osh_nxt;
      so_r    <= so_nxt;
      oe_r    <= oe_nxt;
      stby_r  <= stby_nxt;
      pmask_r <= pmask_nxt;
    end
  end

  // Array content is nonvolatile, so it has no reset.
  always_ff @(posedge i_ref_clk) begin
    if (pb_we) begin
      pbuf[addr_r[3:0]] <= byte_in;
    end
    if (commit) begin
      for (int i = 0; i < PAGE_N; i++) begin
        if (pmask_r[i] &&
            !srlc_locked(lock_r, {addr_r[8:4], PAGE_W'(i)})) begin
          mem[{addr_r[8:4], PAGE_W'(i)}] <= pbuf[i];
        end
      end
    end
  end

  assign o_so      = so_r;
  assign o_so_oe   = oe_r;
  assign o_standby = stby_r;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  a_wel_powerup: assert property (disable iff (1'b0)
    !i_rst_n |=> !wel_r && !o_so_oe && o_standby)
    else $error("latch or output not idle after reset");
  a_standby_quiet: assert property (
    o_standby |-> !o_so_oe && !fr_r)
    else $error("output driven in standby");
  a_set_latch: assert property (
    cs_rise && fr_r && ph_r == PH_SETW && bit_r == 3'h0 &&
    bcnt_r == 3'h1 && !busy_r |=> wel_r)
    else $error("set command did not set latch");
  a_clr_latch: assert property (
    cs_rise && fr_r && ph_r == PH_CLRW && bit_r == 3'h0 &&
    bcnt_r == 3'h1 && !busy_r |=> !wel_r)
    else $error("clear command did not clear latch");
  a_lock_gate: assert property (
    sck_rise && fr_r && ph_r == PH_OPC && bit_r == 3'h7 &&
    byte_in == OP_LOCK && !wel_r |=> ph_r == PH_IGN)
    else $error("lock accepted without latch");
  a_lock_commit: assert property (
    cs_rise && fr_r && ph_r == PH_LOCK && bit_r == 3'h0 &&
    bcnt_r >= 3'h2 && s2_r.wp_n && !busy_r
    |=> busy_r && lock_r == $past(lbuf_r))
    else $error("lock code not committed");
  a_bad_count: assert property (
    cs_rise && bit_r != 3'h0 && !busy_r |=> !busy_r)
    else $error("write started off a byte boundary");
  a_guard_low: assert property (
    !s2_r.wp_n && !busy_r |=> !busy_r)
    else $error("write started with guard low");
  a_busy_high: assert property (
    sck_fall && fr_r && ph_r == PH_STAT && busy_r |=> o_so && o_so_oe)
    else $error("status not high while busy");
  a_wel_autoclr: assert property (
    busy_r && wc_r == '0 |=> !busy_r && !wel_r ##1 !busy_r)
    else $error("latch not cleared at write end");
  a_ignore_quiet: assert property (
    ph_r == PH_IGN && !oe_r |=> !o_so_oe)
    else $error("output driven for unknown opcode");
endmodule
`default_nettype wire

/* testbench/srlc_host_model.sv */
// Host side serial controller model that frames bytes for the lock block.
`timescale 1ns/100ps
`default_nettype none
module srlc_host_model (
  input  wire logic i_ref_clk,
  input  wire logic i_so,
  input  wire logic i_so_oe,
  output var  logic o_cs_n,
  output var  logic o_sck,
  output var  logic o_si
);
  // Select starts low so that the first frame after reset has no fall.
  initial begin
    o_cs_n = 1'b0;
    o_sck  = 1'b0;
    o_si   = 1'b0;
  end

  // Sends the low nbits of data MSB first and samples the output just
  // before each rising serial clock; the clock stands low between frames.
  task automatic xfer(input  logic [31:0] data,
                      input  int          nbits,
                      input  logic        fall,
                      output logic [31:0] rx,
                      output logic [31:0] oe);
    rx = 32'h0;
    oe = 32'h0;
    @(negedge i_ref_clk);
    if (fall) begin
      o_cs_n = 1'b0;
    end
    repeat (4) @(negedge i_ref_clk);
    for (int i = nbits - 1; i >= 0; i--) begin
      o_si = data[i];
      repeat (4) @(negedge i_ref_clk);
      rx = {rx[30:0], i_so};
      oe = {oe[30:0], i_so_oe};
      o_sck = 1'b1;
      repeat (4) @(negedge i_ref_clk);
      o_sck = 1'b0;
    end
    repeat (4) @(negedge i_ref_clk);
    // Select rises right after the last bit the caller asked for.
    o_cs_n = 1'b1;
    // A released data line must not keep looking like valid data.
    o_si = ~o_si;
    repeat (8) @(negedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

/* testbench/srlc_top_test.sv */
// Self-checking bench of the serial lock command block.
`timescale 1ns/100ps
`default_nettype none
module srlc_top_test;
  import srlc_pkg::*;
  localparam int unsigned WC = 300;
  typedef struct packed {
    logic [7:0]  pre1;
    logic [7:0]  pre2;
    logic [31:0] data;
    logic [5:0]  nbits;
    logic        wp;
    logic        commit;
    logic [7:0]  exp;
  } srlc_row_t;
  // Rows 0, 8: no latch; 9: latch cleared; 10: guard low; 11: cut short.
  localparam srlc_row_t ROWS [13] = '{
    '{8'h00, 8'h00, 32'h0107, 6'd16, 1'b1, 1'b0, 8'h00},
    '{8'h06, 8'h00, 32'h0101, 6'd16, 1'b1, 1'b1, 8'h01},
    '{8'h06, 8'h00, 32'h0102, 6'd16, 1'b1, 1'b1, 8'h02},
    '{8'h06, 8'h00, 32'h0103, 6'd16, 1'b1, 1'b1, 8'h03},
    '{8'h06, 8'h00, 32'h0104, 6'd16, 1'b1, 1'b1, 8'h04},
    '{8'h06, 8'h00, 32'h0105, 6'd16, 1'b1, 1'b1, 8'h05},
    '{8'h06, 8'h00, 32'h0106, 6'd16, 1'b1, 1'b1, 8'h06},
    '{8'h06, 8'h00, 32'h010307, 6'd24, 1'b1, 1'b1, 8'h07},
    '{8'h00, 8'h00, 32'h0100, 6'd16, 1'b1, 1'b0, 8'h07},
    '{8'h06, 8'h04, 32'h0100, 6'd16, 1'b1, 1'b0, 8'h07},
    '{8'h06, 8'h00, 32'h0100, 6'd16, 1'b0, 1'b0, 8'h07},
    '{8'h06, 8'h00, 32'h0080, 6'd15, 1'b1, 1'b0, 8'h07},
    '{8'h06, 8'h00, 32'h0100, 6'd16, 1'b1, 1'b1, 8'h00}
  };
  logic        clk;
  logic        rst_n;
  logic        wp_n;
  wire logic   cs_n;
  wire logic   sck;
  wire logic   si;
  logic        so;
  logic        so_oe;
  logic        standby;
  int          failures;
  int          tests_run;
  logic [31:0] rx;
  logic [31:0] oe;

  srlc_top #(.WC_CYCLES(WC)) u_dut (
    .i_ref_clk (clk),
    .i_rst_n   (rst_n),
    .i_cs_n    (cs_n),
    .i_sck     (sck),
    .i_si      (si),
    .i_wp_n    (wp_n),
    .o_so      (so),
    .o_so_oe   (so_oe),
    .o_standby (standby)
  );

  srlc_host_model u_host (
    .i_ref_clk (clk),
    .i_so      (so),
    .i_so_oe   (so_oe),
    .o_cs_n    (cs_n),
    .o_sck     (sck),
    .o_si      (si)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] %0t ns: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    if (failures == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic read_status(input logic [7:0] want);
    logic [31:0] srx;
    logic [31:0] soe;
    u_host.xfer({16'h0, OP_RD_STAT, 8'h00}, 16, 1'b1, srx, soe);
    check(soe, 32'h00ff);
    check({24'h0, srx[7:0]}, {24'h0, want});
  endtask

  task automatic run_row(input srlc_row_t r);
    logic [31:0] rrx;
    logic [31:0] roe;
    wp_n = r.wp;
    u_host.xfer({24'h0, r.pre1}, 8, 1'b1, rrx, roe);
    check(roe, 32'h0);
    u_host.xfer({24'h0, r.pre2}, 8, 1'b1, rrx, roe);
    check(roe, 32'h0);
    u_host.xfer(r.data, r.nbits, 1'b1, rrx, roe);
    check({31'h0, standby}, {31'h0, ~r.commit});
    wp_n = 1'b1;
    read_status(r.commit ? 8'hff : r.exp);
    repeat (WC) @(negedge clk);
    check({31'h0, standby}, 32'h1);
    read_status(r.exp);
  endtask

  // Byte write under a freshly set latch, then wait out the write cycle.
  task automatic mem_write(input logic [31:0] frame);
    logic [31:0] mrx;
    logic [31:0] moe;
    u_host.xfer(32'h06, 8, 1'b1, mrx, moe);
    u_host.xfer(frame, 32, 1'b1, mrx, moe);
    repeat (WC + 20) @(negedge clk);
  endtask

  // Reads one byte at a nine-bit address and checks data and drive.
  task automatic mem_read(input logic [8:0] addr, input logic [7:0] want);
    logic [31:0] drx;
    logic [31:0] doe;
    u_host.xfer({OP_READ, 7'h00, addr, 8'h00}, 32, 1'b1, drx, doe);
    check({24'h0, drx[7:0]}, {24'h0, want});
    check(doe, 32'h000000ff);
  endtask

  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    failures = 0;
    tests_run = 0;
    repeat (4) @(negedge clk);
    check({29'h0, so_oe, standby, so}, 32'h2);
    rst_n = 1'b1;
    repeat (PUW_CYC) @(negedge clk);
    // Select was low across reset, so this frame has no opening fall.
    u_host.xfer({16'h0, OP_RD_STAT, 8'h00}, 16, 1'b0, rx, oe);
    check(oe, 32'h0);
    foreach (ROWS[k]) begin
      run_row(ROWS[k]);
    end
    mem_write(32'h0201f0a5);
    run_row(ROWS[7]);
    mem_write(32'h0201f05a);
    mem_read(9'h1f0, 8'ha5);
    // Just below the locked top page the array still takes writes.
    mem_write(32'h0201e03c);
    mem_read(9'h1e0, 8'h3c);
    // An unknown opcode keeps the output released through a second byte.
    u_host.xfer(32'h0700, 16, 1'b1, rx, oe);
    check(oe, 32'h0);
    // A reset in mid-run drops a latch that was set just before it.
    u_host.xfer(32'h06, 8, 1'b1, rx, oe);
    rst_n = 1'b0;
    repeat (4) @(negedge clk);
    check({29'h0, so_oe, standby, so}, 32'h2);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    u_host.xfer(32'h0105, 16, 1'b1, rx, oe);
    check({31'h0, standby}, 32'h1);
    stop_test();
  end

  initial begin
    repeat (PUW_CYC + 40000) @(posedge clk);
    failures++;
    stop_test();
  end
endmodule
`default_nettype wire
